// >>> hdl/link_consts.svh
// Frame constants shared by the command master and the command slave
// What this block does
// R1 - Read 03H: command 8 bytes, reply 7-37
// R2 - Loopback 08H echoes the 8-byte frame unchanged
// R3 - Write 10H: command 11-41, reply 8 bytes
// R4 - Checksum register preset to all ones
// R5 - XOR byte, eight shifts, fold A001H
// R6 - Checksum order: address, function, data high-first
// R7 - Two checksum bytes end every frame
// R8 - Master checksums exactly the bytes it sends
// R9 - Device recomputes checksum to catch corruption
// R10 - At most 16 registers per read
// R11 - Read carries start then count, high first
// R12 - Read reply: address, function, byte count, data
// R13 - Register values go upper byte first
// R14 - Failure reply: function plus 80H, error code
// R15 - Loopback test code and data echoed unaltered
// R16 - Write carries start, count, byte count, values
// R17 - Write byte count equals twice register count
// R18 - Accept own station address or broadcast zero
// R19 - Checksum low byte sent before high byte
// R20 - Drop bad-checksum or foreign frames silently
// R21 - Never answer a broadcast frame
`ifndef LINK_CONSTS_SVH
`define LINK_CONSTS_SVH
`define CRC_INIT    16'hffff
`define CRC_POLY    16'ha001
`define FC_READ     8'h03
`define FC_LOOP     8'h08
`define FC_WRITE    8'h10
`define EXC_BIT     8'h80
`define EXC_FUNC    8'h01
`define EXC_DATA    8'h03
`define BCAST_ADDR  8'h00
`define MAX_REGS    16
`define FRAME_MAX   41
`define RSP_MAX     37
`define FIX_LEN     6'h08
`define WR_MIN      6'h0b
`define RD_HDR      3
`define WR_HDR      7
`define ECHO_LEN    6'h06
`define RSP_TIMEOUT 100000
`endif

// >>> hdl/link_pkg.sv
// Types and checksum step shared by both ends of the register link
`include "link_consts.svh"
package link_pkg;
  typedef enum logic [4:0] {
    D_RX    = 5'h01,
    D_CHECK = 5'h02,
    D_FETCH = 5'h04,
    D_WRITE = 5'h08,
    D_TX    = 5'h10
  } dev_state_t;

  typedef enum logic [3:0] {
    M_IDLE = 4'h1,
    M_TX   = 4'h2,
    M_RSP  = 4'h4,
    M_EVAL = 4'h8
  } mst_state_t;

  typedef struct packed {
    dev_state_t                  st;
    logic [`FRAME_MAX-1:0][7:0]  buff;
    logic [5:0]                  cnt;
    logic [5:0]                  len;
    logic [15:0]                 crc;
    logic [15:0]                 base;
    logic [4:0]                  idx;
    logic [4:0]                  last;
    logic                        ph;
    logic                        bcast;
    logic                        drop;
    logic                        rd_en;
    logic [15:0]                 rd_addr;
    logic                        wr_en;
    logic [15:0]                 wr_addr;
    logic [15:0]                 wr_data;
    logic                        tx_valid;
    logic [7:0]                  tx_data;
    logic                        tx_last;
  } dev_reg_t;

  typedef struct packed {
    mst_state_t                  st;
    logic [`FRAME_MAX-1:0][7:0]  buff;
    logic [`RSP_MAX-1:0][7:0]    rbuf;
    logic [5:0]                  cnt;
    logic [5:0]                  len;
    logic [15:0]                 crc;
    logic [19:0]                 timer;
    logic                        busy;
    logic                        done;
    logic                        err;
    logic                        exc;
    logic [7:0]                  code;
    logic [255:0]                words;
    logic                        tx_valid;
    logic [7:0]                  tx_data;
    logic                        tx_last;
  } mst_reg_t;

  // One byte through the checksum: XOR in low end, eight shifts
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// >>> hdl/serial_link_if.sv
// Byte-stream link between the command master and the command slave
`timescale 1ns/1ns
`default_nettype none
interface serial_link_if (
  input wire logic clk,     // System clock
  input wire logic resetn   // Asynchronous reset, active low
);
  logic       m_valid;      // Master byte valid
  logic [7:0] m_data;       // Master byte
  logic       m_last;       // Last byte of master frame
  logic       s_valid;      // Slave byte valid
  logic [7:0] s_data;       // Slave byte
  logic       s_last;       // Last byte of slave frame
  modport master (output m_valid, m_data, m_last,
                  input  s_valid, s_data, s_last);
  modport slave  (input  m_valid, m_data, m_last,
                  output s_valid, s_data, s_last);
endinterface
`default_nettype wire

// >>> hdl/reg_slave.sv
// Slave end: frame check, command decode, register access, replies
`timescale 1ns/1ns
`default_nettype none
`include "link_consts.svh"
module reg_slave
  import link_pkg::*;
(
  input  wire logic        clk,      // System clock
  input  wire logic        resetn,   // Async reset, active low
  serial_link_if.slave     lnk,      // Byte link to the master
  input  wire logic [4:0]  station,  // Own station address
  output logic             rd_en,    // Register read strobe
  output logic [15:0]      rd_addr,  // Register read address
  input  wire logic [15:0] rd_data,  // Read value, same cycle
  output logic             wr_en,    // Register write strobe
  output logic [15:0]      wr_addr,  // Register write address
  output logic [15:0]      wr_data   // Register write value
);
  dev_reg_t    q;
  dev_reg_t    d;
  logic [7:0]  fc;
  logic [15:0] qty;
  logic [7:0]  bc;
  logic [7:0]  code;
  logic [5:0]  p;
  logic        hit;

  // Next-state logic of the whole slave
  always_comb begin
    fc   = q.buff[1];
    qty  = {q.buff[4], q.buff[5]};
    bc   = q.buff[6];
    code = 8'h00;
    p    = 6'(`RD_HDR + 2 * q.idx);
    hit  = 1'b0;
    d          = q;
    d.rd_en    = 1'b0;
    d.wr_en    = 1'b0;
    d.tx_valid = 1'b0;
    d.tx_last  = 1'b0;
    unique case (q.st)
      D_RX: begin
        if (lnk.m_valid) begin
          if (q.cnt < 6'(`FRAME_MAX)) begin
            d.buff[q.cnt] = lnk.m_data;
            d.cnt         = q.cnt + 6'h01;
          end else begin
            d.drop = 1'b1;     // Overlong frame is dropped
          end
          // R9 running checksum
          d.crc = crc_step(q.crc, lnk.m_data);
          if (lnk.m_last) begin
            d.st = D_CHECK;
          end
        end
      end
      D_CHECK: begin
        d.st    = D_RX;
        d.cnt   = 6'h00;
        // R4 preset for next frame
        d.crc   = `CRC_INIT;
        d.drop  = 1'b0;
        d.idx   = 5'h00;
        d.ph    = 1'b0;
        d.base  = {q.buff[2], q.buff[3]};
        d.last  = 5'(qty - 16'h0001);
        d.bcast = (q.buff[0] == `BCAST_ADDR);
        // R18 own address or broadcast
        hit = (q.buff[0] == {3'h0, station}) || d.bcast;
        // R20 residue zero means intact frame
        if (!q.drop && q.crc == 16'h0000 && q.cnt >= 6'h04 && hit) begin
          unique case (fc)
            // R1 R10 R11 read command checks
            `FC_READ: begin
              if (q.cnt != `FIX_LEN || qty == 16'h0000 ||
                  qty > 16'(`MAX_REGS)) begin
                code = `EXC_DATA;
              end else begin
                // R12 byte count twice register count
                d.buff[2] = 8'(2 * qty);
                d.len     = 6'(`RD_HDR + 2 * qty);
                d.st      = D_FETCH;
              end
            end
            // R2 R15 loopback keeps frame as received
            `FC_LOOP: begin
              if (q.cnt != `FIX_LEN) begin
                code = `EXC_DATA;
              end else begin
                d.len = `ECHO_LEN;
                d.st  = D_TX;
              end
            end
            // R3 R16 R17 write command checks
            `FC_WRITE: begin
              if (q.cnt < `WR_MIN || qty == 16'h0000 ||
                  qty > 16'(`MAX_REGS) || {8'h00, bc} != 16'(2 * qty) ||
                  {3'h0, q.cnt} != 9'({1'b0, bc} + 9'h009)) begin
                code = `EXC_DATA;
              end else begin
                d.len = `ECHO_LEN;
                d.st  = D_WRITE;
              end
            end
            default: code = `EXC_FUNC;
          endcase
          // R14 exception reply
          if (code != 8'h00) begin
            d.buff[1] = fc | `EXC_BIT;
            d.buff[2] = code;
            d.len     = 6'(`RD_HDR);
            d.st      = D_TX;
          end
        end
      end
      // R12 R13 fetch registers ascending, high byte first
      D_FETCH: begin
        if (!q.ph) begin
          d.rd_en   = 1'b1;
          d.rd_addr = q.base + 16'(q.idx);
          d.ph      = 1'b1;
        end else begin
          d.buff[p]         = rd_data[15:8];
          d.buff[p + 6'h01] = rd_data[7:0];
          d.ph              = 1'b0;
          d.idx             = q.idx + 5'h01;
          if (q.idx == q.last) begin
            d.st = D_TX;
          end
        end
      end
      // R13 R16 write values ascending from start
      D_WRITE: begin
        p         = 6'(`WR_HDR + 2 * q.idx);
        d.wr_en   = 1'b1;
        d.wr_addr = q.base + 16'(q.idx);
        d.wr_data = {q.buff[p], q.buff[p + 6'h01]};
        d.idx     = q.idx + 5'h01;
        if (q.idx == q.last) begin
          d.st = D_TX;
        end
      end
      D_TX: begin
        d.tx_valid = 1'b1;
        d.cnt      = q.cnt + 6'h01;
        if (q.cnt < q.len) begin
          d.tx_data = q.buff[q.cnt];
          // R6 R8 checksum over sent bytes
          d.crc     = crc_step(q.crc, q.buff[q.cnt]);
        end else if (q.cnt == q.len) begin
          // R7 R19 checksum low byte first
          d.tx_data = q.crc[7:0];
        end else begin
          d.tx_data = q.crc[15:8];
          d.tx_last = 1'b1;
          d.st      = D_RX;
          d.cnt     = 6'h00;
          d.crc     = `CRC_INIT;
        end
      end
      default: d.st = D_RX;
    endcase
    // R21 broadcast runs but never replies
    if (d.st == D_TX && q.st != D_TX && d.bcast) begin
      d.st = D_RX;
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q     <= '0;
      q.st  <= D_RX;
      q.crc <= `CRC_INIT;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign rd_en       = q.rd_en;
  assign rd_addr     = q.rd_addr;
  assign wr_en       = q.wr_en;
  assign wr_addr     = q.wr_addr;
  assign wr_data     = q.wr_data;
  assign lnk.s_valid = q.tx_valid;
  assign lnk.s_data  = q.tx_data;
  assign lnk.s_last  = q.tx_last;
endmodule
`default_nettype wire

// >>> hdl/reg_master.sv
// Master end: builds command frames, sends them, checks the reply
`timescale 1ns/1ns
`default_nettype none
`include "link_consts.svh"
module reg_master
  import link_pkg::*;
#(
  parameter logic [19:0] RSP_TIMEOUT = 20'(`RSP_TIMEOUT)
)(
  input  wire logic         clk,       // System clock
  input  wire logic         resetn,    // Async reset, active low
  serial_link_if.master     lnk,       // Byte link to the slave
  input  wire logic         req,       // Start a command, pulse
  input  wire logic [7:0]   req_slave, // Target address, 0 broadcast
  input  wire logic [7:0]   req_fc,    // Function code
  input  wire logic [15:0]  req_addr,  // Start address or test code
  input  wire logic [15:0]  req_qty,   // Register count or test data
  input  wire logic [255:0] req_wdata, // Write words, word i at 16*i
  output logic              busy,      // Command in progress
  output logic              done,      // Command finished, pulse
  output logic              rsp_err,   // Checksum, reply address, echo or timeout
  output logic              rsp_exc,   // Exception reply received
  output logic [7:0]        rsp_code,  // Exception code
  output logic [255:0]      rsp_words  // Read words, word i at 16*i
);
  mst_reg_t q;
  mst_reg_t d;

  // Next-state logic of the whole master
  always_comb begin
    d          = q;
    d.done     = 1'b0;
    d.tx_valid = 1'b0;
    d.tx_last  = 1'b0;
    unique case (q.st)
      M_IDLE: begin
        if (req) begin
          // R11 R16 header fields, high byte first
          d.buff[0] = req_slave;
          d.buff[1] = req_fc;
          d.buff[2] = req_addr[15:8];
          d.buff[3] = req_addr[7:0];
          d.buff[4] = req_qty[15:8];
          d.buff[5] = req_qty[7:0];
          // R17 byte count twice register count
          d.buff[6] = 8'(2 * req_qty);
          // R13 write words upper byte first
          for (int i = 0; i < `MAX_REGS; i++) begin
            d.buff[`WR_HDR + 2 * i]     = req_wdata[16 * i + 8 +: 8];
            d.buff[`WR_HDR + 2 * i + 1] = req_wdata[16 * i +: 8];
          end
          d.len  = (req_fc == `FC_WRITE) ?
                   6'(`WR_HDR + 2 * req_qty) : `ECHO_LEN;
          d.cnt  = 6'h00;
          // R4 preset before first byte
          d.crc  = `CRC_INIT;
          d.busy = 1'b1;
          d.err  = 1'b0;
          d.exc  = 1'b0;
          d.st   = M_TX;
        end
      end
      M_TX: begin
        d.tx_valid = 1'b1;
        d.cnt      = q.cnt + 6'h01;
        if (q.cnt < q.len) begin
          d.tx_data = q.buff[q.cnt];
          // R5 R6 R8 checksum over sent bytes only
          d.crc     = crc_step(q.crc, q.buff[q.cnt]);
        end else if (q.cnt == q.len) begin
          // R7 R19 checksum low byte first
          d.tx_data = q.crc[7:0];
        end else begin
          d.tx_data = q.crc[15:8];
          d.tx_last = 1'b1;
          d.cnt     = 6'h00;
          d.crc     = `CRC_INIT;
          d.timer   = 20'h00000;
          d.st      = M_RSP;
          // R21 broadcast expects no reply
          if (q.buff[0] == `BCAST_ADDR) begin
            d.st   = M_IDLE;
            d.busy = 1'b0;
            d.done = 1'b1;
          end
        end
      end
      M_RSP: begin
        d.timer = q.timer + 20'h00001;
        if (lnk.s_valid) begin
          if (q.cnt < 6'(`RSP_MAX)) begin
            d.rbuf[q.cnt] = lnk.s_data;
            d.cnt         = q.cnt + 6'h01;
          end
          // R9 reply checked the same way
          d.crc = crc_step(q.crc, lnk.s_data);
          if (lnk.s_last) begin
            d.st = M_EVAL;
          end
        end else if (q.timer >= RSP_TIMEOUT) begin
          d.err  = 1'b1;
          d.busy = 1'b0;
          d.done = 1'b1;
          d.st   = M_IDLE;
        end
      end
      M_EVAL: begin
        d.err  = q.crc != 16'h0000 || q.rbuf[0] != q.buff[0];
        // R14 exception flag and code
        d.exc  = q.rbuf[1] == (q.buff[1] | `EXC_BIT);
        d.code = q.rbuf[2];
        // R15 loopback must come back unaltered
        if (!d.exc && q.buff[1] == `FC_LOOP &&
            q.rbuf[5:0] != q.buff[5:0]) begin
          d.err = 1'b1;
        end
        // R12 read data follows the byte count
        for (int i = 0; i < `MAX_REGS; i++) begin
          d.words[16 * i +: 16] = {q.rbuf[`RD_HDR + 2 * i],
                                   q.rbuf[`RD_HDR + 2 * i + 1]};
        end
        d.busy = 1'b0;
        d.done = 1'b1;
        d.st   = M_IDLE;
      end
      default: d.st = M_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q     <= '0;
      q.st  <= M_IDLE;
      q.crc <= `CRC_INIT;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign busy        = q.busy;
  assign done        = q.done;
  assign rsp_err     = q.err;
  assign rsp_exc     = q.exc;
  assign rsp_code    = q.code;
  assign rsp_words   = q.words;
  assign lnk.m_valid = q.tx_valid;
  assign lnk.m_data  = q.tx_data;
  assign lnk.m_last  = q.tx_last;
endmodule
`default_nettype wire

// >>> dv/link_properties.sv
// Concurrent checks on the byte link between master and slave
`timescale 1ns/1ns
`default_nettype none
module link_properties (
  input wire logic       clk,     // System clock
  input wire logic       resetn,  // Async reset, active low
  input wire logic       m_valid, // Master byte valid
  input wire logic [7:0] m_data,  // Master byte
  input wire logic       m_last,  // Master frame end
  input wire logic       s_valid, // Slave byte valid
  input wire logic [7:0] s_data,  // Slave byte
  input wire logic       s_last   // Slave frame end
);
  logic [15:0] mc_q, sc_q, mc_d, sc_d;
  logic [5:0]  mi_q, si_q;
  logic [7:0]  mb_q [8];
  // Checksum step kept apart from the design's own
  function automatic logic [15:0] fold(input logic [15:0] c,
                                       input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
    end
    return r;
  endfunction
  assign mc_d = fold(mc_q, m_data);
  assign sc_d = fold(sc_q, s_data);
  // Running checksums, byte positions and the master's header
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mc_q <= 16'hffff;
      sc_q <= 16'hffff;
      mi_q <= 6'h00;
      si_q <= 6'h00;
    end else begin
      if (m_valid) begin
        mc_q <= m_last ? 16'hffff : mc_d;
        mi_q <= m_last ? 6'h00 : mi_q + 6'h01;
        if (mi_q < 6'h08) mb_q[mi_q[2:0]] <= m_data;
      end
      if (s_valid) begin
        sc_q <= s_last ? 16'hffff : sc_d;
        si_q <= s_last ? 6'h00 : si_q + 6'h01;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  mlast_valid_a: assert property (m_last |-> m_valid)
    else $error("master frame end without a byte");
  slast_valid_a: assert property (s_last |-> s_valid)
    else $error("slave frame end without a byte");
  master_crc_a: assert property (m_valid && m_last |-> mc_d == 16'h0000)
    else $error("master frame checksum wrong");
  slave_crc_a: assert property (s_valid && s_last |-> sc_d == 16'h0000)
    else $error("slave frame checksum wrong");
  check_cycle_a: assert property (m_valid && m_last |=> !s_valid)
    else $error("reply started without a check cycle");
  reply_burst_a: assert property (s_valid && !s_last |=> s_valid)
    else $error("reply bytes not back to back");
  echo_data_a: assert property (s_valid && mb_q[1] == 8'h08 &&
    si_q < 6'h08 |-> s_data == mb_q[si_q[2:0]])
    else $error("loopback byte altered");
  reply_addr_a: assert property (s_valid && si_q == 6'h00 |->
    s_data == mb_q[0] && s_data != 8'h00)
    else $error("reply address wrong");
  reply_func_a: assert property (s_valid && si_q == 6'h01 |->
    s_data == mb_q[1] || s_data == (mb_q[1] | 8'h80))
    else $error("reply function code wrong");
  read_count_a: assert property (s_valid && si_q == 6'h02 &&
    $past(s_data) == 8'h03 |-> s_data == {mb_q[5][6:0], 1'b0})
    else $error("read reply byte count wrong");
endmodule
`default_nettype wire

// >>> dv/serial_register_command_slave_bench.sv
// Bench joining command master and slave across the byte link
`timescale 1ns/1ns
`default_nettype none
module serial_register_command_slave_bench;
  logic         clk = 1'b0;
  logic         resetn = 1'b0;
  logic         req = 1'b0;
  logic [7:0]   req_slave = 8'h00;
  logic [7:0]   req_fc = 8'h00;
  logic [15:0]  req_addr = 16'h0000;
  logic [15:0]  req_qty = 16'h0000;
  logic [255:0] req_wdata = '0;
  logic         busy, done, rsp_err, rsp_exc, rd_en, wr_en;
  logic [7:0]   rsp_code;
  logic [255:0] rsp_words;
  logic [15:0]  rd_addr, rd_data, wr_addr, wr_data;
  logic [7:0]   mq [$];
  logic [7:0]   sq [$];
  logic [31:0]  wq [$];
  logic [15:0]  rq [$];
  logic [31:0]  ex_tab [3] = '{32'h0300_1103, 32'h0300_0003, 32'h0500_0101};
  int           num_errors = 0;
  int           num_checks = 0;
  int           cycles = 0;
  always #5 clk = ~clk;
  serial_link_if lnk_i (.clk(clk), .resetn(resetn));
  reg_master #(.RSP_TIMEOUT(20'd200)) reg_master_i (.clk(clk),
    .resetn(resetn), .lnk(lnk_i), .req(req), .req_slave(req_slave),
    .req_fc(req_fc), .req_addr(req_addr), .req_qty(req_qty),
    .req_wdata(req_wdata), .busy(busy), .done(done), .rsp_err(rsp_err),
    .rsp_exc(rsp_exc), .rsp_code(rsp_code), .rsp_words(rsp_words));
  reg_slave reg_slave_i (.clk(clk), .resetn(resetn), .lnk(lnk_i),
    .station(5'h01), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
  link_properties link_properties_i (.clk(clk), .resetn(resetn),
    .m_valid(lnk_i.m_valid), .m_data(lnk_i.m_data), .m_last(lnk_i.m_last),
    .s_valid(lnk_i.s_valid), .s_data(lnk_i.s_data), .s_last(lnk_i.s_last));
  // Register file model: value derived from the address
  function automatic logic [15:0] rv(input logic [15:0] a);
    return {a[7:0] ^ 8'h3c, a[15:8]};
  endfunction
  assign rd_data = rv(rd_addr);
  // Log link bytes and register strobes, cut a hang short
  always @(posedge clk) begin
    if (lnk_i.m_valid === 1'b1) mq.push_back(lnk_i.m_data);
    if (lnk_i.s_valid === 1'b1) sq.push_back(lnk_i.s_data);
    if (wr_en === 1'b1) wq.push_back({wr_addr, wr_data});
    if (rd_en === 1'b1) rq.push_back(rd_addr);
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic bytes(input string w, input logic [7:0] q[$],
                       input logic [63:0] v, input int n);
    for (int i = 0; i < n; i++) chk(w, 32'(v[63-8*i -: 8]), 32'(q[i]));
  endtask
  // Issue one command and wait for its completion pulse
  task automatic run(input logic [7:0] sl, input logic [7:0] fc,
                     input logic [15:0] ad, input logic [15:0] qt,
                     input logic [255:0] wd);
    int n;
    mq.delete();
    sq.delete();
    wq.delete();
    rq.delete();
    req_slave = sl;
    req_fc = fc;
    req_addr = ad;
    req_qty = qt;
    req_wdata = wd;
    req = 1'b1;
    @(posedge clk);
    #1 req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 600) begin
      @(posedge clk);
      #1 n++;
    end
    chk("done", 32'h1, 32'(done));
  endtask
  task automatic outcome(input logic e, input logic x, input logic [7:0] c,
                         input int n);
    chk("rsp_err", 32'(e), 32'(rsp_err));
    chk("rsp_exc", 32'(x), 32'(rsp_exc));
    if (x) chk("rsp_code", 32'(c), 32'(rsp_code));
    chk("reply length", 32'(n), 32'(sq.size()));
  endtask
  // Main sequence of commands
  initial begin
    repeat (12) @(posedge clk);
    #1 resetn = 1'b1;
    run(8'h01, 8'h08, 16'h0000, 16'ha537, '0);
    outcome(1'b0, 1'b0, 8'h00, 8);
    bytes("loop command", mq, 64'h0108_0000_a537_da8d, 8);
    bytes("loop reply", sq, 64'h0108_0000_a537_da8d, 8);
    run(8'h01, 8'h10, 16'h0001, 16'h0002, 256'h0258_0001);
    outcome(1'b0, 1'b0, 8'h00, 8);
    chk("write count", 32'h2, 32'(wq.size()));
    chk("write 0", 32'h0001_0001, wq[0]);
    chk("write 1", 32'h0002_0258, wq[1]);
    bytes("write reply", sq, 64'h0110_0001_0002_0000, 6);
    run(8'h01, 8'h03, 16'h0100, 16'h0010, '0);
    outcome(1'b0, 1'b0, 8'h00, 37);
    bytes("read reply", sq, 64'h0103_203c_0100_0000, 5);
    chk("read count", 32'h10, 32'(rq.size()));
    for (int i = 0; i < 16; i++) begin
      chk("read addr", 32'(16'h0100 + i), 32'(rq[i]));
      chk("read word", 32'(rv(16'h0100 + i)), 32'(rsp_words[16*i +: 16]));
    end
    for (int i = 0; i < 3; i++) begin
      run(8'h01, ex_tab[i][31:24], 16'h0000, ex_tab[i][23:8], '0);
      outcome(1'b0, 1'b1, ex_tab[i][7:0], 5);
    end
    run(8'h00, 8'h10, 16'h0040, 16'h0001, 256'hbeef);
    // Broadcast ends at the last sent byte; let the slave check and write
    repeat (40) @(posedge clk);
    #1;
    outcome(1'b0, 1'b0, 8'h00, 0);
    chk("broadcast write", 32'h0040_beef, wq[0]);
    run(8'h07, 8'h08, 16'h0000, 16'h1234, '0);
    outcome(1'b1, 1'b0, 8'h00, 0);
    give_verdict();
  end
endmodule
`default_nettype wire
